// ### rtl/diag_wd_consts.vh
/*
  Constants for the diagnostic counters and watchdogs: register byte offsets,
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef DIAG_WD_CONSTS_VH
`define DIAG_WD_CONSTS_VH

// ==========================================================
// register byte offsets
`define OFS_PROC_UNIT_ERR   12'h30c
`define OFS_HOST_ERR_COUNT  12'h30d
`define OFS_HOST_ERR_CODE   12'h30e
`define OFS_LOST_LINK0      12'h310
`define OFS_LOST_LINK3      12'h313
`define OFS_WATCHDOG_INCREMENT_DIVIDER_LO   12'h400
`define OFS_WATCHDOG_INCREMENT_DIVIDER_HI   12'h401
`define OFS_HOST_WD_TIME_LO 12'h410
`define OFS_HOST_WD_TIME_HI 12'h411
`define OFS_PROC_WD_TIME_LO 12'h420
`define OFS_PROC_WD_TIME_HI 12'h421
`define OFS_PROC_WD_STAT_LO 12'h440
`define OFS_PROC_WD_STAT_HI 12'h441
`define OFS_PROC_WD_COUNT   12'h442
`define OFS_HOST_WD_COUNT   12'h443

// ==========================================================
// field positions of the host-port error code and the application event bit
`define ERRCODE_CYCLES_MSB  2
`define ERRCODE_BUSY_BIT    3
`define ERRCODE_NOTERM_BIT  4
`define ERRCODE_PAST_BIT    5
`define APP_EVT_WD_BIT      6

// ==========================================================
// reset values and limits
`define COUNT_MAX           8'hff
`define WD_TIME_DISABLED    16'h0000
`define WD_TIME_RESET       16'h03e8
`define WD_DIV_RESET        16'h4e20

// ==========================================================
// timing
`define CLK_PERIOD_PS       5000
`define WD_INCREMENT_NS     100000

`endif

// ### rtl/wd_timer.v
/*
  One watchdog timer: counts basic increments since its last restart, sets
  expired and pulses expiredPulse when the count reaches the time setting.
  Assumes a one-cycle increment tick shared by all watchdogs.
*/
`timescale 1ns/1ps
`include "diag_wd_consts.vh"

module wd_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire             mclk,
  input  wire             reset,
  // control
  input  wire [WIDTH-1:0] timeSetting,
  input  wire             tick,
  input  wire             restart,
  // state
  output reg              expired,
  output reg              expiredPulse
);

  reg [WIDTH-1:0] elapsed_q;
  reg             done_q;
  wire            enabled = (timeSetting != `WD_TIME_DISABLED);

  // ==========================================================
  // increment counting; expiry fires once, then waits for a restart
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      elapsed_q    <= {WIDTH{1'b0}};
      done_q       <= 1'b0;
      expired      <= 1'b0;
      expiredPulse <= 1'b0;
    end else begin
      expiredPulse <= 1'b0;
      if (!enabled || restart) begin
        elapsed_q <= {WIDTH{1'b0}};
        done_q    <= 1'b0;
        expired   <= 1'b0;
      end else if (tick && !done_q) begin
        if (elapsed_q + {{(WIDTH-1){1'b0}}, 1'b1} >= timeSetting) begin
          done_q       <= 1'b1;
          expired      <= 1'b1;
          expiredPulse <= 1'b1;
        end
        elapsed_q <= elapsed_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ### rtl/diag_counters_and_watchdogs.v
/*
  Diagnostic error counters and the host-port and process-data watchdogs of
  a fieldbus slave controller, with two byte-wide register ports: one for
  the network side and one for the host port.
  Assumes all event inputs are one-cycle pulses synchronous to mclk and that
  a register access is one cycle of strobe with address and data.
*/
//
// Behaviour
// - processing-unit error counter counts frame errors, saturating at 0xff
// - a network-side write clears the processing-unit error counter; host writes do not
// - host-port error counter counts interface errors, saturating at 0xff
// - writing host-port error counter clears it and the error code
// - error code bits 2:0 hold access clock cycles modulo 8
// - error code flags busy, missing termination, continuation; bits 7:6 command
// - four lost-link counters saturate, count only with port loop automatic
// - lost links count only on open ports
// - writing any lost-link counter clears all four
// - watchdog times are 16-bit counts of basic increments, default 100ms
// - host watchdog off at zero, else restarted by each host access
// - one process watchdog, off at zero, restarted by triggering buffer writes
// - process watchdog status reads 0 expired, 1 running or disabled
// - no write ack: host read of status clears event; writes ignored
// - write ack: host write of status clears event, value ignored
// - process watchdog expiry counter saturates at 0xff
// - host watchdog expiry counter saturates at 0xff
// - writing either expiry counter clears both
// - event bit 6 set on process watchdog expiry, held until acknowledged
`timescale 1ns/1ps
`include "diag_wd_consts.vh"

module diag_counters_and_watchdogs #(
  parameter PORTS     = 4,
  parameter CNT_WIDTH = 8,
  parameter WD_WIDTH  = 16
) (
  // clock and reset
  input  wire                   mclk,
  input  wire                   reset,
  // network side register port
  input  wire [11:0]            netAddr,
  input  wire                   netWrite,
  input  wire                   netRead,
  input  wire [7:0]             netWdata,
  output reg  [7:0]             netRdata,
  // host port register port
  input  wire [11:0]            hostAddr,
  input  wire                   hostWrite,
  input  wire                   hostRead,
  input  wire [7:0]             hostWdata,
  output reg  [7:0]             hostRdata,
  input  wire                   writeAckMode,
  // error events
  input  wire                   frameError,
  input  wire                   hostPortError,
  input  wire [7:0]             spiCycles,
  input  wire                   spiBusyViolation,
  input  wire                   spiNoReadTerm,
  input  wire                   spiPastTerm,
  input  wire [2:0]             spiCommand,
  input  wire [PORTS-1:0]       linkLost,
  input  wire [PORTS-1:0]       portOpen,
  input  wire [PORTS-1:0]       portLoopAuto,
  // watchdog triggers
  input  wire                   bufferWdWrite,
  // state out
  output wire                   processWdEvent,
  output wire                   hostWdExpired
);

  reg  [CNT_WIDTH-1:0]       procErr_q;
  reg  [CNT_WIDTH-1:0]       hostErr_q;
  reg  [7:0]                 errCode_q;
  reg  [PORTS*CNT_WIDTH-1:0] lostLink_q;
  reg  [WD_WIDTH-1:0]        divider_q;
  reg  [WD_WIDTH-1:0]        hostWdTime_q;
  reg  [WD_WIDTH-1:0]        procWdTime_q;
  reg  [CNT_WIDTH-1:0]       procWdCnt_q;
  reg  [CNT_WIDTH-1:0]       hostWdCnt_q;
  reg                        wdEvent_q;
  reg  [WD_WIDTH-1:0]        divCnt_q;
  reg                        tick_q;

  wire procExpired;
  wire procExpPulse;
  wire hostExpPulse;

  // network side write decodes
  wire wrProcErr  = netWrite && (netAddr == `OFS_PROC_UNIT_ERR);
  wire wrHostErr  = netWrite && (netAddr == `OFS_HOST_ERR_COUNT);
  wire wrLostLink = netWrite && (netAddr >= `OFS_LOST_LINK0) && (netAddr <= `OFS_LOST_LINK3);
  wire wrWdCount  = netWrite && ((netAddr == `OFS_PROC_WD_COUNT) || (netAddr == `OFS_HOST_WD_COUNT));

  // host acknowledgement of the process watchdog event
  wire hostStatAddr = (hostAddr == `OFS_PROC_WD_STAT_LO) || (hostAddr == `OFS_PROC_WD_STAT_HI);
  wire ackRead      = !writeAckMode && hostRead && hostStatAddr;
  wire ackWrite     = writeAckMode && hostWrite && hostStatAddr;

  function [CNT_WIDTH-1:0] satInc;
    input [CNT_WIDTH-1:0] v;
    begin
      satInc = (v == `COUNT_MAX) ? v : v + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    end
  endfunction

  // ==========================================================
  // error counters; a write clears, a same-cycle event still lands
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      procErr_q <= {CNT_WIDTH{1'b0}};
      hostErr_q <= {CNT_WIDTH{1'b0}};
      errCode_q <= 8'h00;
    end else begin
      if (frameError)
        procErr_q <= wrProcErr ? {{(CNT_WIDTH-1){1'b0}}, 1'b1} : satInc(procErr_q);
      else if (wrProcErr)
        procErr_q <= {CNT_WIDTH{1'b0}};
      if (hostPortError) begin
        hostErr_q <= wrHostErr ? {{(CNT_WIDTH-1){1'b0}}, 1'b1} : satInc(hostErr_q);
        errCode_q <= {spiCommand[2:1], spiPastTerm, spiNoReadTerm,
                      spiBusyViolation, spiCycles[`ERRCODE_CYCLES_MSB:0]};
      end else if (wrHostErr) begin
        hostErr_q <= {CNT_WIDTH{1'b0}};
        errCode_q <= 8'h00;
      end
    end
  end

  // ==========================================================
  // lost-link counters, one per port
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : gLost
      wire countIt = linkLost[p] && portOpen[p] && portLoopAuto[p];
      always @(posedge mclk or posedge reset) begin
        if (reset)
          lostLink_q[p*CNT_WIDTH +: CNT_WIDTH] <= {CNT_WIDTH{1'b0}};
        else if (countIt)
          lostLink_q[p*CNT_WIDTH +: CNT_WIDTH] <= wrLostLink ? {{(CNT_WIDTH-1){1'b0}}, 1'b1} :
                                                  satInc(lostLink_q[p*CNT_WIDTH +: CNT_WIDTH]);
        else if (wrLostLink)
          lostLink_q[p*CNT_WIDTH +: CNT_WIDTH] <= {CNT_WIDTH{1'b0}};
      end
    end
  endgenerate

  // ==========================================================
  // settings, written by the network side only
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      divider_q    <= `WD_DIV_RESET;
      hostWdTime_q <= `WD_TIME_RESET;
      procWdTime_q <= `WD_TIME_RESET;
    end else if (netWrite) begin
      case (netAddr)
        `OFS_WATCHDOG_INCREMENT_DIVIDER_LO:   divider_q[7:0]     <= netWdata;
        `OFS_WATCHDOG_INCREMENT_DIVIDER_HI:   divider_q[15:8]    <= netWdata;
        `OFS_HOST_WD_TIME_LO: hostWdTime_q[7:0]  <= netWdata;
        `OFS_HOST_WD_TIME_HI: hostWdTime_q[15:8] <= netWdata;
        `OFS_PROC_WD_TIME_LO: procWdTime_q[7:0]  <= netWdata;
        `OFS_PROC_WD_TIME_HI: procWdTime_q[15:8] <= netWdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // basic increment tick; divider counts in clocks, zero treated as one
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      divCnt_q <= {WD_WIDTH{1'b0}};
      tick_q   <= 1'b0;
    end else if (divCnt_q + {{(WD_WIDTH-1){1'b0}}, 1'b1} >= divider_q) begin
      divCnt_q <= {WD_WIDTH{1'b0}};
      tick_q   <= 1'b1;
    end else begin
      divCnt_q <= divCnt_q + {{(WD_WIDTH-1){1'b0}}, 1'b1};
      tick_q   <= 1'b0;
    end
  end

  wd_timer #(.WIDTH(WD_WIDTH)) uHostWd (
    .mclk         (mclk),
    .reset        (reset),
    .timeSetting  (hostWdTime_q),
    .tick         (tick_q),
    .restart      (hostRead || hostWrite),
    .expired      (hostWdExpired),
    .expiredPulse (hostExpPulse)
  );

  wd_timer #(.WIDTH(WD_WIDTH)) uProcWd (
    .mclk         (mclk),
    .reset        (reset),
    .timeSetting  (procWdTime_q),
    .tick         (tick_q),
    .restart      (bufferWdWrite),
    .expired      (procExpired),
    .expiredPulse (procExpPulse)
  );

  // ==========================================================
  // expiry counters and the application event bit
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      procWdCnt_q <= {CNT_WIDTH{1'b0}};
      hostWdCnt_q <= {CNT_WIDTH{1'b0}};
      wdEvent_q   <= 1'b0;
    end else begin
      if (procExpPulse)
        procWdCnt_q <= wrWdCount ? {{(CNT_WIDTH-1){1'b0}}, 1'b1} : satInc(procWdCnt_q);
      else if (wrWdCount)
        procWdCnt_q <= {CNT_WIDTH{1'b0}};
      if (hostExpPulse)
        hostWdCnt_q <= wrWdCount ? {{(CNT_WIDTH-1){1'b0}}, 1'b1} : satInc(hostWdCnt_q);
      else if (wrWdCount)
        hostWdCnt_q <= {CNT_WIDTH{1'b0}};
      // new expiry wins over a same-cycle acknowledge
      if (procExpPulse)
        wdEvent_q <= 1'b1;
      else if (ackRead || ackWrite)
        wdEvent_q <= 1'b0;
    end
  end

  assign processWdEvent = wdEvent_q;

  // ==========================================================
  // read mux shared by both ports
  function [7:0] regRead;
    input [11:0] a;
    begin
      case (a)
        `OFS_PROC_UNIT_ERR:   regRead = procErr_q;
        `OFS_HOST_ERR_COUNT:  regRead = hostErr_q;
        `OFS_HOST_ERR_CODE:   regRead = errCode_q;
        12'h310:              regRead = lostLink_q[7:0];
        12'h311:              regRead = lostLink_q[15:8];
        12'h312:              regRead = lostLink_q[23:16];
        `OFS_LOST_LINK3:      regRead = lostLink_q[31:24];
        `OFS_WATCHDOG_INCREMENT_DIVIDER_LO:   regRead = divider_q[7:0];
        `OFS_WATCHDOG_INCREMENT_DIVIDER_HI:   regRead = divider_q[15:8];
        `OFS_HOST_WD_TIME_LO: regRead = hostWdTime_q[7:0];
        `OFS_HOST_WD_TIME_HI: regRead = hostWdTime_q[15:8];
        `OFS_PROC_WD_TIME_LO: regRead = procWdTime_q[7:0];
        `OFS_PROC_WD_TIME_HI: regRead = procWdTime_q[15:8];
        `OFS_PROC_WD_STAT_LO: regRead = {7'h00, ~procExpired};
        `OFS_PROC_WD_COUNT:   regRead = procWdCnt_q;
        `OFS_HOST_WD_COUNT:   regRead = hostWdCnt_q;
        default:              regRead = 8'h00;
      endcase
    end
  endfunction

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      netRdata  <= 8'h00;
      hostRdata <= 8'h00;
    end else begin
      if (netRead)
        netRdata <= regRead(netAddr);
      if (hostRead)
        hostRdata <= regRead(hostAddr);
    end
  end

endmodule

// ### sim/diag_counters_and_watchdogs_sva.sv
/*
  Checker of the diagnostic counters and watchdogs at the top-level ports.
  Assumes it is bound into the top module and reads come one cycle late.
*/
`timescale 1ns/1ps
module diag_counters_and_watchdogs_sva #(
  parameter PORTS = 4
) (
  // clock and reset
  input wire             mclk,
  input wire             reset,
  // register ports
  input wire [11:0]      netAddr,
  input wire             netWrite,
  input wire             netRead,
  input wire [7:0]       netRdata,
  input wire [11:0]      hostAddr,
  input wire             hostWrite,
  input wire             hostRead,
  input wire             writeAckMode,
  // events and state
  input wire             frameError,
  input wire             hostPortError,
  input wire [7:0]       spiCycles,
  input wire             spiBusyViolation,
  input wire             spiNoReadTerm,
  input wire             spiPastTerm,
  input wire [2:0]       spiCommand,
  input wire [PORTS-1:0] linkLost,
  input wire             bufferWdWrite,
  input wire             processWdEvent,
  input wire             hostWdExpired
);
  // ==========================================================
  // expected error code; a new fault wins over the clear
  reg [7:0] codeExp_q;
  always @(posedge mclk or posedge reset) begin
    if (reset)
      codeExp_q <= 8'h00;
    else if (hostPortError)
      codeExp_q <= {spiCommand[2:1], spiPastTerm, spiNoReadTerm, spiBusyViolation, spiCycles[2:0]};
    else if (netWrite && netAddr == 12'h30d)
      codeExp_q <= 8'h00;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================
  // assertions
  a_err_code: assert property (netRead && netAddr == 12'h30e |=> netRdata == $past(codeExp_q))
    else $error("error code differs from the last faulty access");
  a_unit_clear: assert property (netWrite && netAddr == 12'h30c && !frameError ##1 !frameError
    ##1 netRead && netAddr == 12'h30c |=> netRdata == 8'h00) else $error("unit error count not cleared");
  a_links_clear: assert property (netWrite && netAddr[11:2] == 10'h0c4 && !(|linkLost) ##1 !(|linkLost)
    ##1 netRead && netAddr[11:2] == 10'h0c4 |=> netRdata == 8'h00) else $error("lost links not cleared");
  a_host_restart: assert property ((hostRead || hostWrite) |=> !hostWdExpired)
    else $error("host watchdog expired right after a host access");
  a_host_rise: assert property ($rose(hostWdExpired) |-> !$past(hostRead) && !$past(hostWrite))
    else $error("host watchdog expired despite a host access");
  a_ack_read: assert property (hostRead && !writeAckMode && hostAddr == 12'h440 && processWdEvent
    && !bufferWdWrite |=> !processWdEvent) else $error("status read did not clear the event");
  a_ack_write: assert property (hostWrite && writeAckMode && hostAddr == 12'h440 && processWdEvent
    && !bufferWdWrite |=> !processWdEvent) else $error("status write did not clear the event");
  a_event_holds: assert property (processWdEvent && !netWrite && !bufferWdWrite && !hostRead
    && !(hostWrite && writeAckMode) |=> processWdEvent) else $error("event dropped without acknowledge");
endmodule

bind diag_counters_and_watchdogs diag_counters_and_watchdogs_sva #(.PORTS(PORTS)) chk_u (
  .mclk(mclk), .reset(reset), .netAddr(netAddr), .netWrite(netWrite), .netRead(netRead),
  .netRdata(netRdata), .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
  .writeAckMode(writeAckMode), .frameError(frameError), .hostPortError(hostPortError),
  .spiCycles(spiCycles), .spiBusyViolation(spiBusyViolation), .spiNoReadTerm(spiNoReadTerm),
  .spiPastTerm(spiPastTerm), .spiCommand(spiCommand), .linkLost(linkLost),
  .bufferWdWrite(bufferWdWrite), .processWdEvent(processWdEvent), .hostWdExpired(hostWdExpired)
);

// ### sim/fieldbus_partner.sv
/*
  Far side of the block: the network master's frames and link events and the
  host processor's faulty accesses and buffer writes, as one-cycle pulses.
  Assumes the caller enters its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module fieldbus_partner (
  // clock
  input  wire        mclk,
  // events toward the block
  output logic       frameError,
  output logic       hostPortError,
  output logic [7:0] spiCycles,
  output logic       spiBusyViolation,
  output logic       spiNoReadTerm,
  output logic       spiPastTerm,
  output logic [2:0] spiCommand,
  output logic [3:0] linkLost,
  output logic       bufferWdWrite
);
  initial begin
    {frameError, hostPortError, linkLost, bufferWdWrite} = 7'h00;
    {spiCycles, spiBusyViolation, spiNoReadTerm, spiPastTerm, spiCommand} = 14'h2aaa;
  end
  // ==========================================================
  // pulse trains, one idle cycle between pulses
  task automatic events(input int n, input logic fe, input logic [3:0] ll, input logic bw);
    repeat (n) begin
      frameError <= fe;
      linkLost <= ll;
      bufferWdWrite <= bw;
      @(posedge mclk);
      {frameError, linkLost, bufferWdWrite} <= 6'h00;
      @(posedge mclk);
    end
  endtask
  // fault fields: cycles, busy, no termination, past termination, command
  task automatic spiFault(input logic [13:0] f);
    hostPortError <= 1'b1;
    {spiCycles, spiBusyViolation, spiNoReadTerm, spiPastTerm, spiCommand} <= f;
    @(posedge mclk);
    hostPortError <= 1'b0;
    // fields are meaningless outside the pulse, so never leave them valid
    {spiCycles, spiBusyViolation, spiNoReadTerm, spiPastTerm, spiCommand} <= ~f;
    @(posedge mclk);
  endtask
endmodule

// ### sim/diag_counters_and_watchdogs_tb.sv
/*
  Testbench: byte register accesses on both ports and directed tests.
  Assumes the partner model and the bound checker.
*/
`timescale 1ns/1ps
`include "diag_wd_consts.vh"
module diag_counters_and_watchdogs_tb;
  logic        mclk = 1'b0, reset = 1'b1, netWrite = 1'b0, netRead = 1'b0;
  logic        hostWrite = 1'b0, hostRead = 1'b0, writeAckMode = 1'b0;
  logic [11:0] netAddr = 12'h000, hostAddr = 12'h000;
  logic [7:0]  netWdata = 8'h00, hostWdata = 8'h00, netRdata, hostRdata, spiCycles;
  logic [3:0]  portOpen = 4'h0, portLoopAuto = 4'h0, linkLost;
  logic [2:0]  spiCommand;
  logic        frameError, hostPortError, spiBusyViolation, spiNoReadTerm, spiPastTerm;
  logic        bufferWdWrite, processWdEvent, hostWdExpired;
  int          mismatches = 0, n_checks = 0, cycles = 0;
  always #2.5 mclk = ~mclk;
  diag_counters_and_watchdogs dut_u (
    .mclk(mclk), .reset(reset), .netAddr(netAddr), .netWrite(netWrite), .netRead(netRead),
    .netWdata(netWdata), .netRdata(netRdata), .hostAddr(hostAddr), .hostWrite(hostWrite),
    .hostRead(hostRead), .hostWdata(hostWdata), .hostRdata(hostRdata), .writeAckMode(writeAckMode),
    .frameError(frameError), .hostPortError(hostPortError), .spiCycles(spiCycles),
    .spiBusyViolation(spiBusyViolation), .spiNoReadTerm(spiNoReadTerm), .spiPastTerm(spiPastTerm),
    .spiCommand(spiCommand), .linkLost(linkLost), .portOpen(portOpen), .portLoopAuto(portLoopAuto),
    .bufferWdWrite(bufferWdWrite), .processWdEvent(processWdEvent), .hostWdExpired(hostWdExpired));
  fieldbus_partner ev_u (
    .mclk(mclk), .frameError(frameError), .hostPortError(hostPortError), .spiCycles(spiCycles),
    .spiBusyViolation(spiBusyViolation), .spiNoReadTerm(spiNoReadTerm), .spiPastTerm(spiPastTerm),
    .spiCommand(spiCommand), .linkLost(linkLost), .bufferWdWrite(bufferWdWrite));
  // ==========================================================
  // tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle cycle after each access keeps strobes from being set twice in one step
  task automatic wr(input logic host, input logic [11:0] a, input logic [7:0] d);
    if (host) {hostAddr, hostWdata, hostWrite} <= {a, d, 1'b1};
    else {netAddr, netWdata, netWrite} <= {a, d, 1'b1};
    @(posedge mclk);
    {hostWrite, netWrite} <= 2'b00;
    @(posedge mclk);
  endtask
  task automatic rdc(input logic host, input logic [11:0] a, input logic [7:0] exp,
                     input logic [7:0] m = 8'hff);
    if (host) {hostAddr, hostRead} <= {a, 1'b1};
    else {netAddr, netRead} <= {a, 1'b1};
    @(posedge mclk);
    {hostRead, netRead} <= 2'b00;
    @(posedge mclk);
    check((host ? hostRdata : netRdata) & m, exp);
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      report_and_stop;
    end
  end
  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdc(0, `OFS_WATCHDOG_INCREMENT_DIVIDER_LO, 8'(`WD_DIV_RESET));
    rdc(0, `OFS_WATCHDOG_INCREMENT_DIVIDER_HI, 8'(`WD_DIV_RESET >> 8));
    rdc(1, `OFS_PROC_WD_TIME_HI, 8'(`WD_TIME_RESET >> 8));
    ev_u.events(3, 1'b1, 4'h0, 1'b0);
    rdc(1, `OFS_PROC_UNIT_ERR, 8'h03);
    wr(1, `OFS_PROC_UNIT_ERR, 8'h00);
    rdc(0, `OFS_PROC_UNIT_ERR, 8'h03);
    ev_u.events(260, 1'b1, 4'h0, 1'b0);
    rdc(0, `OFS_PROC_UNIT_ERR, `COUNT_MAX);
    wr(0, `OFS_PROC_UNIT_ERR, 8'h5a);
    rdc(0, `OFS_PROC_UNIT_ERR, 8'h00);
    $display("test frame errors done");
    ev_u.spiFault({8'h0b, 3'b101, 3'b110});
    rdc(0, `OFS_HOST_ERR_COUNT, 8'h01);
    rdc(0, `OFS_HOST_ERR_CODE, 8'heb);
    ev_u.spiFault({8'h14, 3'b010, 3'b001});
    rdc(0, `OFS_HOST_ERR_CODE, 8'h14);
    repeat (255) ev_u.spiFault({8'h07, 3'b000, 3'b010});
    rdc(0, `OFS_HOST_ERR_COUNT, `COUNT_MAX);
    wr(0, `OFS_HOST_ERR_COUNT, 8'h33);
    rdc(0, `OFS_HOST_ERR_COUNT, 8'h00);
    rdc(0, `OFS_HOST_ERR_CODE, 8'h00);
    $display("test host port errors done");
    portOpen <= 4'b0111;
    portLoopAuto <= 4'b1011;
    ev_u.events(3, 1'b0, 4'hf, 1'b0);
    for (int i = 0; i < 4; i++) rdc(0, 12'(`OFS_LOST_LINK0 + i), (i < 2) ? 8'h03 : 8'h00);
    ev_u.events(255, 1'b0, 4'h1, 1'b0);
    rdc(0, `OFS_LOST_LINK0, `COUNT_MAX);
    wr(0, `OFS_LOST_LINK3, 8'h77);
    for (int i = 0; i < 4; i++) rdc(0, 12'(`OFS_LOST_LINK0 + i), 8'h00);
    $display("test lost links done");
    // short divider and times keep each expiry within some tens of cycles
    wr(0, `OFS_HOST_WD_TIME_LO, 8'h00);
    wr(0, `OFS_HOST_WD_TIME_HI, 8'h00);
    wr(0, `OFS_WATCHDOG_INCREMENT_DIVIDER_LO, 8'h04);
    wr(0, `OFS_WATCHDOG_INCREMENT_DIVIDER_HI, 8'h00);
    wr(1, `OFS_WATCHDOG_INCREMENT_DIVIDER_LO, 8'h99);
    rdc(0, `OFS_WATCHDOG_INCREMENT_DIVIDER_LO, 8'h04);
    wr(0, `OFS_PROC_WD_TIME_HI, 8'h00);
    wr(0, `OFS_PROC_WD_TIME_LO, 8'h08);
    ev_u.events(1, 1'b0, 4'h0, 1'b1);
    rdc(1, `OFS_PROC_WD_STAT_LO, 8'h01, 8'h01);
    wr(0, `OFS_HOST_WD_COUNT, 8'h00);
    rdc(0, `OFS_PROC_WD_COUNT, 8'h00);
    repeat (60) @(posedge mclk);
    rdc(0, `OFS_PROC_WD_STAT_LO, 8'h00, 8'h01);
    check({7'h0, processWdEvent}, 8'h01);
    rdc(0, `OFS_PROC_WD_COUNT, 8'h01);
    wr(1, `OFS_PROC_WD_STAT_LO, 8'h00);
    check({7'h0, processWdEvent}, 8'h01);
    rdc(1, `OFS_PROC_WD_STAT_LO, 8'h00, 8'h01);
    check({7'h0, processWdEvent}, 8'h00);
    writeAckMode <= 1'b1;
    ev_u.events(1, 1'b0, 4'h0, 1'b1);
    repeat (60) @(posedge mclk);
    rdc(1, `OFS_PROC_WD_COUNT, 8'h02);
    rdc(1, `OFS_PROC_WD_STAT_LO, 8'h00, 8'h01);
    check({7'h0, processWdEvent}, 8'h01);
    wr(1, `OFS_PROC_WD_STAT_LO, 8'h00);
    check({7'h0, processWdEvent}, 8'h00);
    wr(0, `OFS_PROC_WD_TIME_LO, 8'h00);
    ev_u.events(1, 1'b0, 4'h0, 1'b1);
    repeat (60) @(posedge mclk);
    rdc(0, `OFS_PROC_WD_STAT_LO, 8'h01, 8'h01);
    rdc(0, `OFS_PROC_WD_COUNT, 8'h02);
    wr(0, `OFS_HOST_WD_TIME_LO, 8'h08);
    rdc(1, `OFS_HOST_WD_COUNT, 8'h00);
    repeat (60) @(posedge mclk);
    check({7'h0, hostWdExpired}, 8'h01);
    rdc(0, `OFS_HOST_WD_COUNT, 8'h01);
    rdc(1, `OFS_HOST_ERR_CODE, 8'h00);
    check({7'h0, hostWdExpired}, 8'h00);
    wr(0, `OFS_HOST_WD_TIME_LO, 8'h00);
    wr(0, `OFS_PROC_WD_COUNT, 8'h00);
    rdc(0, `OFS_HOST_WD_COUNT, 8'h00);
    rdc(0, `OFS_PROC_WD_COUNT, 8'h00);
    $display("test watchdogs done");
    report_and_stop;
  end
endmodule
